/* ubp_regs.vh */
// Register map, field positions, reset values and sizes of the rx buffer block
`ifndef UBP_REGS_VH
`define UBP_REGS_VH
`define UBP_ADDR_RX_STATUS 8'h19
`define UBP_ADDR_RX_SPACE 8'h1b
`define UBP_ADDR_TXQ_SEL 8'h95
`define UBP_ADDR_FETCH_PTR 8'h97
`define UBP_ADDR_STORE_PTR 8'h99
`define UBP_ADDR_NEXT_PTR 8'h9b
`define UBP_ADDR_FLAG_WR 8'h0a
`define UBP_ADDR_FLAG_RD 8'h0b
`define UBP_ADDR_EN_WR 8'h0c
`define UBP_ADDR_EN_RD 8'h0d
`define UBP_CMD_RXBUF_RD 8'h93
`define UBP_CMD_SKIP 8'h94
`define UBP_BIT_FIRST 2
`define UBP_BIT_FAULT 1
`define UBP_BIT_RXERR_FLAG 0
`define UBP_TXQ_SEND_LSB 2
`define UBP_DEPTH 8'h3e
`define UBP_LAST_LOC 8'h3d
`define UBP_RST_SPACE 8'h3e
`define UBP_RST_FETCH 8'h00
`define UBP_RST_STORE 8'h01
`define UBP_RST_NEXT 8'h00
`define UBP_SPI_BITS 3'h7
`endif

/* ubp_fifo.v */
// Small valid/ready FIFO with registered full and empty flags
`timescale 1ns/1ps
module ubp_fifo #(
   parameter WIDTH = 10,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   input wire clock,
   input wire rst,
   input wire in_valid,
   input wire [WIDTH-1:0] in_data,
   output wire in_ready,
   output wire out_valid,
   output wire [WIDTH-1:0] out_data,
   input wire out_ready
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   reg full_q;
   reg empty_q;
   wire push = in_valid & ~full_q;
   wire pop = out_ready & ~empty_q;
   wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   localparam [AW:0] DEPTH_C = DEPTH[AW:0];
   localparam integer LAST_I = DEPTH - 1;
   localparam [AW-1:0] LAST_C = LAST_I[AW-1:0];

   assign in_ready = ~full_q;
   assign out_valid = ~empty_q;
   assign out_data = mem_q[rd_q];

   always @(posedge clock) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         full_q <= 1'b0;
         empty_q <= 1'b1;
      end else begin
         if (push) begin
            wr_q <= (wr_q == LAST_C) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == LAST_C) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         cnt_q <= cnt_d;
         full_q <= (cnt_d == DEPTH_C);
         empty_q <= (cnt_d == {(AW+1){1'b0}});
      end
   end
endmodule // ubp_fifo

/* ubp_spi_slave.v */
// SPI mode 0 slave, pins oversampled by the system clock
`timescale 1ns/1ps
`include "ubp_regs.vh"
module ubp_spi_slave (
   input wire clock,
   input wire rst,
   input wire sclk,
   input wire cs_n,
   input wire mosi,
   input wire [7:0] tx_byte,
   output reg byte_done,
   output reg [7:0] rx_byte,
   output reg first_byte,
   output reg miso,
   output reg miso_oe
);
   reg [2:0] s1_q;
   reg [2:0] s2_q;
   reg sclk_prev_q;
   reg [2:0] cnt_q;
   reg [7:0] sh_in_q;
   reg [7:0] sh_out_q;
   reg first_q;
   wire sclk_s = s2_q[0];
   wire cs_s_n = s2_q[1];
   wire mosi_s = s2_q[2];
   wire rise = sclk_s & ~sclk_prev_q;
   wire fall = ~sclk_s & sclk_prev_q;

   always @(posedge clock) begin
      if (rst) begin
         s1_q <= 3'h2;
         s2_q <= 3'h2;
         sclk_prev_q <= 1'b0;
         cnt_q <= 3'h0;
         sh_in_q <= 8'h00;
         sh_out_q <= 8'h00;
         first_q <= 1'b1;
         byte_done <= 1'b0;
         rx_byte <= 8'h00;
         first_byte <= 1'b0;
         miso <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         s1_q <= {mosi, cs_n, sclk};
         s2_q <= s1_q;
         sclk_prev_q <= sclk_s;
         miso_oe <= ~cs_s_n;
         byte_done <= 1'b0;
         if (cs_s_n) begin
            cnt_q <= 3'h0;
            first_q <= 1'b1;
            sh_out_q <= 8'h00;
            miso <= 1'b0;
         end else if (rise) begin
            sh_in_q <= {sh_in_q[6:0], mosi_s};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == `UBP_SPI_BITS) begin
               byte_done <= 1'b1;
               rx_byte <= {sh_in_q[6:0], mosi_s};
               first_byte <= first_q;
               first_q <= 1'b0;
            end
         end else if (fall) begin
            // Next byte is loaded at the fall after a byte, when the
            // caller has had several clocks to prepare it
            if (cnt_q == 3'h0 && !first_q) begin
               miso <= tx_byte[7];
               sh_out_q <= {tx_byte[6:0], 1'b0};
            end else begin
               miso <= sh_out_q[7];
               sh_out_q <= {sh_out_q[6:0], 1'b0};
            end
         end
      end
   end
endmodule // ubp_spi_slave

/* ubp_top.v */
// Receive buffer, pointers, status and interrupt flag behind an SPI port
//
// Contract
// (R1) Reserved register bits always read zero
// (R2) Bit 2 marks first byte of message
// (R3) Bit 1 marks Manchester or parity fault
// (R4) Fault bit is the rx error flag source
// (R5) Free space register, resets to 62
// (R6) Send queue selector, two bits, reset zero; read straight from the tx_send_queue input, which no reset touches
// (R7) Load queue selector, two bits, reset zero; read straight from the load_queue_sel input, which no reset touches
// (R8) Fetch pointer resets zero, advances on reads
// (R9) Store pointer resets one, tracks UART writes
// (R10) Next message pointer resets zero
// (R11) Skip command copies next into fetch
// (R12) Status bits follow condition level, no latch
// (R13) Flag sets on enabled status rising edge
// (R14) Flag cleared only by writing zero
// (R15) Status already high does not set flag
// (R16) Interrupt pin low while flag set
// (R17) Pointers wrap at 62, space tracks fill
`timescale 1ns/1ps
`include "ubp_regs.vh"
module ubp_top (
   input wire clock,
   input wire rst,
   input wire spi_sclk,
   input wire spi_cs_n,
   input wire spi_mosi,
   output wire spi_miso,
   output wire spi_miso_oe,
   output reg int_n,
   input wire rx_in_valid,
   input wire [7:0] rx_in_data,
   input wire rx_in_first,
   input wire rx_in_err,
   output reg rx_in_ready,
   input wire [1:0] tx_send_queue,
   input wire [1:0] load_queue_sel
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RREG = 3'h1;
   localparam [2:0] ST_RBUF = 3'h2;
   localparam [2:0] ST_WRITE = 3'h3;
   localparam [2:0] ST_DONE = 3'h4;
   localparam [2:0] FIFO_FULL = 3'h4;

   reg [7:0] data_mem_q [0:61];
   reg [61:0] first_mem_q;
   reg [61:0] err_mem_q;
   reg [7:0] fetch_q, fetch_d;
   reg [7:0] store_q, store_d;
   reg [7:0] next_q, next_d;
   reg [7:0] used_q, used_d;
   reg pend_q, pend_d;
   reg [2:0] st_q;
   reg [2:0] st_d;
   reg [2:0] fill_q, fill_d;
   reg [7:0] addr_q;
   reg [7:0] tx_q;
   reg en_q;
   reg flag_q, flag_d;
   reg err_prev_q;
   reg [7:0] rd_val;
   reg [7:0] skip_used;
   wire byte_done;
   wire [7:0] byte_val;
   wire byte_first;
   wire f_valid;
   wire f_ready;
   wire take_in = rx_in_valid & rx_in_ready;
   wire [9:0] f_data;

   function [7:0] wrap_inc;
      input [7:0] p;
      begin
         wrap_inc = (p == `UBP_LAST_LOC) ? 8'h00 : p + 8'h01;
      end
   endfunction

   ubp_spi_slave u_spi (
      .clock(clock),
      .rst(rst),
      .sclk(spi_sclk),
      .cs_n(spi_cs_n),
      .mosi(spi_mosi),
      .tx_byte(tx_q),
      .byte_done(byte_done),
      .rx_byte(byte_val),
      .first_byte(byte_first),
      .miso(spi_miso),
      .miso_oe(spi_miso_oe)
   );

   // Absorbs UART bytes while the buffer is full; its ready is left open, rx_in_ready is registered from fill_d
   ubp_fifo #(.WIDTH(10), .DEPTH(FIFO_FULL), .AW(2)) u_fifo (
      .clock(clock),
      .rst(rst),
      .in_valid(take_in),
      .in_data({rx_in_first, rx_in_err, rx_in_data}),
      .in_ready(),
      .out_valid(f_valid),
      .out_data(f_data),
      .out_ready(f_ready)
   );

   // (R17) stall when full
   assign f_ready = (used_q != `UBP_DEPTH);
   wire store_en = f_valid & f_ready;
   wire have_data = (used_q != 8'h00);
   // (R9) slot one behind store
   wire [7:0] wr_loc = (store_q == 8'h00) ? `UBP_LAST_LOC : store_q - 8'h01;
   wire [5:0] wr_idx = wr_loc[5:0];
   wire [5:0] rd_idx = fetch_q[5:0];

   // (R2) first-byte status
   wire stat_first = have_data & first_mem_q[rd_idx];
   // (R3) fault status
   // (R12) pure level of the byte at the fetch pointer
   wire stat_fault = have_data & err_mem_q[rd_idx];

   wire cmd_rbuf = byte_done & byte_first & (byte_val == `UBP_CMD_RXBUF_RD);
   wire cmd_skip = byte_done & byte_first & (byte_val == `UBP_CMD_SKIP);
   wire more_rbuf = byte_done & ~byte_first & (st_q == ST_RBUF);
   wire rd_en = (cmd_rbuf | more_rbuf) & have_data;
   wire wr_data = byte_done & ~byte_first & (st_q == ST_WRITE);
   wire [7:0] sel_addr = byte_first ? byte_val : addr_q;

   genvar gi;
   generate
      for (gi = 0; gi < 62; gi = gi + 1) begin : g_ent
         always @(posedge clock) begin
            if (store_en && wr_idx == gi) begin
               data_mem_q[gi] <= f_data[7:0];
               first_mem_q[gi] <= f_data[9];
               err_mem_q[gi] <= f_data[8];
            end
         end
      end
   endgenerate

   // (R1) unmapped and reserved bits read zero
   always @* begin
      rd_val = 8'h00;
      case (sel_addr)
         `UBP_ADDR_RX_STATUS: begin
            rd_val[`UBP_BIT_FIRST] = stat_first;
            rd_val[`UBP_BIT_FAULT] = stat_fault;
         end
         // (R5) free space report
         `UBP_ADDR_RX_SPACE: rd_val = `UBP_DEPTH - used_q;
         // (R6) send selector
         // (R7) load selector
         `UBP_ADDR_TXQ_SEL: rd_val = {4'h0, tx_send_queue, load_queue_sel};
         `UBP_ADDR_FETCH_PTR: rd_val = fetch_q;
         `UBP_ADDR_STORE_PTR: rd_val = store_q;
         `UBP_ADDR_NEXT_PTR: rd_val = next_q;
         `UBP_ADDR_FLAG_RD: rd_val[`UBP_BIT_RXERR_FLAG] = flag_q;
         `UBP_ADDR_EN_RD: rd_val[`UBP_BIT_RXERR_FLAG] = en_q;
         default: rd_val = 8'h00;
      endcase
   end

   // Bytes left after a skip, counted from the new fetch point
   always @* begin
      skip_used = used_q;
      if (next_q != fetch_q) begin
         if (wr_loc >= next_q) begin
            skip_used = wr_loc - next_q;
         end else begin
            skip_used = wr_loc + `UBP_DEPTH - next_q;
         end
      end
   end

   always @* begin
      fetch_d = fetch_q;
      store_d = store_q;
      next_d = next_q;
      pend_d = pend_q;
      used_d = used_q;
      // (R11) skip to next message
      if (cmd_skip) begin
         fetch_d = next_q;
         used_d = skip_used;
         pend_d = 1'b0;
      end else if (rd_en) begin
         // (R8) advance on host read
         fetch_d = wrap_inc(fetch_q);
         used_d = used_q - 8'h01;
         if (pend_q && fetch_q == next_q) begin
            pend_d = 1'b0;
         end
      end
      if (store_en) begin
         // (R17) wrap and count
         store_d = wrap_inc(store_q);
         used_d = used_d + 8'h01;
         // (R10) capture start of message
         if (f_data[9] && !pend_d) begin
            next_d = wr_loc;
            pend_d = 1'b1;
         end
      end
   end

   // Own count of FIFO words: ready stays a flop yet is never stale
   always @* begin
      fill_d = fill_q;
      if (take_in) begin
         fill_d = fill_d + 3'h1;
      end
      if (f_valid && f_ready) begin
         fill_d = fill_d - 3'h1;
      end
   end

   // Frame decode: the first byte picks the kind of frame
   always @* begin
      st_d = st_q;
      if (byte_done && byte_first) begin
         if (byte_val == `UBP_CMD_RXBUF_RD) begin
            st_d = ST_RBUF;
         end else if (byte_val == `UBP_CMD_SKIP) begin
            st_d = ST_DONE;
         end else if (byte_val[0]) begin
            st_d = ST_RREG;
         end else begin
            st_d = ST_WRITE;
         end
      end else if (byte_done) begin
         case (st_q)
            // One data byte per write, later bytes are ignored
            ST_WRITE: st_d = ST_DONE;
            ST_RREG: st_d = ST_RREG;
            ST_RBUF: st_d = ST_RBUF;
            ST_DONE: st_d = ST_DONE;
            default: st_d = ST_IDLE;
         endcase
      end
   end

   // (R13) enabled rising edge sets
   // (R4) fault bit is the source
   // (R15) high level alone never sets
   wire err_rise = stat_fault & ~err_prev_q;
   always @* begin
      flag_d = flag_q;
      // (R14) only a written zero clears
      if (wr_data && addr_q == `UBP_ADDR_FLAG_WR &&
          !byte_val[`UBP_BIT_RXERR_FLAG]) begin
         flag_d = 1'b0;
      end
      // A new event in the clearing cycle must not be lost
      if (err_rise && en_q) begin
         flag_d = 1'b1;
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         fetch_q <= `UBP_RST_FETCH;
         store_q <= `UBP_RST_STORE;
         next_q <= `UBP_RST_NEXT;
         used_q <= `UBP_DEPTH - `UBP_RST_SPACE;
         pend_q <= 1'b0;
         st_q <= ST_IDLE;
         fill_q <= 3'h0;
         addr_q <= 8'h00;
         tx_q <= 8'h00;
         en_q <= 1'b0;
         flag_q <= 1'b0;
         err_prev_q <= 1'b0;
         int_n <= 1'b1;
         rx_in_ready <= 1'b0;
      end else begin
         fetch_q <= fetch_d;
         store_q <= store_d;
         next_q <= next_d;
         used_q <= used_d;
         pend_q <= pend_d;
         flag_q <= flag_d;
         err_prev_q <= stat_fault;
         // (R16) active low interrupt
         int_n <= ~flag_q;
         // Room counted after this edge, so ready never promises a full FIFO
         rx_in_ready <= (fill_d != FIFO_FULL);
         fill_q <= fill_d;
         st_q <= st_d;
         if (wr_data && addr_q == `UBP_ADDR_EN_WR) begin
            en_q <= byte_val[`UBP_BIT_RXERR_FLAG];
         end
         if (byte_done) begin
            if (byte_first) begin
               addr_q <= byte_val;
            end
            tx_q <= 8'h00;
            if (cmd_rbuf || more_rbuf) begin
               tx_q <= have_data ? data_mem_q[rd_idx] : 8'h00;
            end else if (byte_first ? byte_val[0] : (st_q == ST_RREG)) begin
               tx_q <= rd_val;
            end
         end
      end
   end
endmodule // ubp_top

/* ubp_top_properties.sv */
// Port-level assertions for the rx buffer block
`timescale 1ns/1ps
module ubp_top_props (
   input wire clock,
   input wire rst,
   input wire spi_sclk,
   input wire spi_cs_n,
   input wire spi_miso,
   input wire spi_miso_oe,
   input wire int_n,
   input wire rx_in_valid,
   input wire rx_in_ready
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_rst_idle;
      $fell(rst) |-> int_n && !spi_miso_oe && !spi_miso;
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("outputs not idle after reset");
   property p_ready_up;
      $fell(rst) |-> !rx_in_ready ##1 rx_in_ready;
   endproperty
   a_ready_up: assert property (p_ready_up)
      else $error("uart side not ready after reset");
   property p_oe_off;
      spi_cs_n[*5] |-> !spi_miso_oe;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("miso driven while deselected");
   property p_oe_on;
      (!spi_cs_n)[*5] |-> spi_miso_oe;
   endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("miso not driven while selected");
   property p_miso_idle;
      spi_cs_n[*5] |-> !spi_miso;
   endproperty
   a_miso_idle: assert property (p_miso_idle)
      else $error("miso not low while deselected");
   property p_miso_steady;
      spi_sclk[*5] |-> $stable(spi_miso);
   endproperty
   a_miso_steady: assert property (p_miso_steady)
      else $error("miso moved while sclk high");
   property p_int_kept;
      spi_cs_n[*8] ##0 !int_n |=> !int_n;
   endproperty
   a_int_kept: assert property (p_int_kept)
      else $error("interrupt dropped without host write");
   property p_int_quiet;
      (spi_cs_n && !rx_in_valid)[*8] ##0 int_n |=> int_n;
   endproperty
   a_int_quiet: assert property (p_int_quiet)
      else $error("interrupt raised with no status change");
endmodule // ubp_top_props
bind ubp_top ubp_top_props u_ubp_top_props (.clock(clock), .rst(rst),
   .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
   .spi_miso_oe(spi_miso_oe), .int_n(int_n), .rx_in_valid(rx_in_valid),
   .rx_in_ready(rx_in_ready));

/* ubp_host_model.sv */
// Host controller acting as SPI mode 0 master
`timescale 1ns/1ps
module ubp_host_model (
   input wire clock,
   input wire spi_miso,
   input wire spi_miso_oe,
   output reg spi_sclk,
   output reg spi_cs_n,
   output reg spi_mosi,
   output reg got_valid,
   output reg [7:0] got_data
);
   reg line_q = 1'b0;
   // Released line shows the inverse so a stale value never passes
   wire line = spi_miso_oe ? spi_miso : ~line_q;
   always @(posedge clock) line_q <= line;
   initial begin
      spi_sclk = 0;
      spi_cs_n = 1;
      spi_mosi = 0;
      got_valid = 0;
      got_data = 8'h00;
   end
   // Half sclk period of 40 ns is five system clocks
   task xfer(input [7:0] a, input [7:0] d, input integer n, input wr);
      integer i;
      reg [7:0] sh;
      begin
         @(negedge clock);
         spi_cs_n = 0;
         repeat (5) @(negedge clock);
         for (i = 0; i <= n; i = i + 1) begin
            sh = (i == 0) ? a : d;
            repeat (8) begin
               spi_mosi = sh[7];
               repeat (5) @(negedge clock);
               spi_sclk = 1;
               sh = {sh[6:0], line};
               repeat (5) @(negedge clock);
               spi_sclk = 0;
            end
            if (i > 0 && !wr) begin
               got_data = sh;
               got_valid = 1;
               @(negedge clock);
               got_valid = 0;
            end
         end
         spi_mosi = ~spi_mosi;
         repeat (5) @(negedge clock);
         spi_cs_n = 1;
         repeat (5) @(negedge clock);
      end
   endtask
endmodule // ubp_host_model

/* ubp_tb.sv */
// Self-checking bench for the rx buffer block
`timescale 1ns/1ps
module tb;
   reg clock = 0;
   reg rst = 1;
   reg rx_in_valid = 0;
   reg [7:0] rx_in_data = 8'h00;
   reg rx_in_first = 0;
   reg rx_in_err = 0;
   reg [1:0] tx_send_queue = 2'h0;
   reg [1:0] load_queue_sel = 2'h0;
   wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, int_n;
   wire rx_in_ready, got_valid;
   wire [7:0] got_data;
   reg [7:0] exp_q[$];
   integer n_mismatch = 0;
   integer compares = 0;
   integer seed = 32'h3d228e27;
   integer i, k;
   reg ok;
   reg fill_phase = 0;
   reg [1:0] s, l;
   always #4 clock = ~clock;
   ubp_top u_ubp_top (.clock(clock), .rst(rst), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .int_n(int_n), .rx_in_valid(rx_in_valid),
      .rx_in_data(rx_in_data), .rx_in_first(rx_in_first),
      .rx_in_err(rx_in_err), .rx_in_ready(rx_in_ready),
      .tx_send_queue(tx_send_queue), .load_queue_sel(load_queue_sel));
   ubp_host_model u_ubp_host_model (.clock(clock), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .got_valid(got_valid), .got_data(got_data));
   task check(input [7:0] seen, input [7:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("compares=%0d mismatches=%0d", compares, n_mismatch);
         if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   always @(posedge clock) begin
      if (got_valid === 1'b1 && exp_q.size() > 0)
         check(got_data, exp_q.pop_front());
      else if (got_valid === 1'b1)
         n_mismatch = n_mismatch + 1;
   end
   task rd(input [7:0] a, input [7:0] e);
      begin
         exp_q.push_back(e);
         u_ubp_host_model.xfer(a, 8'h00, 1, 0);
      end
   endtask
   // Offer one byte; ok drops if the buffer never takes it
   task push(input [7:0] d, input f, input e);
      begin
         k = 0;
         while (rx_in_ready !== 1'b1 && k < 20) begin
            @(negedge clock);
            k = k + 1;
         end
         ok = (k < 20);
         // Only the deliberate fill may run out of room
         if (!ok && !fill_phase)
            n_mismatch = n_mismatch + 1;
         if (ok) begin
            rx_in_valid = 1;
            rx_in_data = d;
            rx_in_first = f;
            rx_in_err = e;
            @(negedge clock);
            rx_in_valid = 0;
            rx_in_data = ~d;
            @(negedge clock);
         end
      end
   endtask
   initial begin
      repeat (16) @(negedge clock);
      rst = 0;
      repeat (5) @(negedge clock);
      for (i = 0; i < 8; i = i + 1)
         rd(8'h19 + 8'h02 * i[7:0] - ((i > 2) ? 8'h6a : 8'h00),
            (i == 1) ? 8'h3e : 8'h00);
      rd(8'h97, 8'h00);
      rd(8'h99, 8'h01);
      rd(8'h9b, 8'h00);
      rd(8'h21, 8'h00);
      check({7'h0, int_n}, 8'h01);
      for (i = 0; i < 4; i = i + 1) begin
         s = $random(seed);
         l = $random(seed);
         tx_send_queue = s;
         load_queue_sel = l;
         rd(8'h95, {4'h0, s, l});
      end
      push(8'ha5, 1, 0);
      push(8'h3c, 0, 1);
      push($random(seed), 0, 0);
      repeat (10) @(negedge clock);
      rd(8'h99, 8'h04);
      rd(8'h1b, 8'h3b);
      rd(8'h19, 8'h04);
      u_ubp_host_model.xfer(8'h0c, 8'h01, 1, 1);
      rd(8'h0d, 8'h01);
      u_ubp_host_model.xfer(8'h93, 8'h00, 0, 0);
      rd(8'h97, 8'h01);
      rd(8'h19, 8'h02);
      rd(8'h0b, 8'h01);
      check({7'h0, int_n}, 8'h00);
      u_ubp_host_model.xfer(8'h0a, 8'h00, 1, 1);
      rd(8'h0b, 8'h00);
      check({7'h0, int_n}, 8'h01);
      u_ubp_host_model.xfer(8'h93, 8'h00, 0, 0);
      rd(8'h19, 8'h00);
      push(8'h77, 1, 1);
      repeat (10) @(negedge clock);
      rd(8'h9b, 8'h03);
      u_ubp_host_model.xfer(8'h94, 8'h00, 0, 0);
      rd(8'h97, 8'h03);
      rd(8'h19, 8'h06);
      check({7'h0, int_n}, 8'h00);
      ok = 1;
      fill_phase = 1;
      for (i = 0; i < 80 && ok; i = i + 1)
         push($random(seed), 0, 0);
      check({7'h0, rx_in_ready}, 8'h00);
      rd(8'h1b, 8'h00);
      for (i = 0; i < 100 && exp_q.size() > 0; i = i + 1)
         @(negedge clock);
      if (exp_q.size() > 0)
         n_mismatch = n_mismatch + 1;
      print_verdict;
   end
endmodule // tb
